// ==== rtl/byte_sequencer.v ====
`timescale 1ns/1ps
`default_nettype none
// Splits a word access to the 8-bit registers into two byte transfers,
// even byte first, then odd byte.
module byte_sequencer (
   input wire i_clk,
   input wire i_arst_n,
   input wire i_req,
   input wire i_word,
   input wire [3:0] i_idx,
   output wire o_busy,
   output wire o_xfer,
   output wire [3:0] o_idx,
   output wire o_second
);
   reg second;
   reg [3:0] idx_hold;
   always @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         second <= 1'b0;
         idx_hold <= 4'h0;
      end else if (second) begin
         second <= 1'b0;
      end else if (i_req && i_word) begin
         second <= 1'b1;
         idx_hold <= i_idx | 4'h1;
      end
   end
   assign o_busy = second;
   assign o_second = second;
   assign o_xfer = second | i_req;
   assign o_idx = second ? idx_hold : (i_word ? (i_idx & 4'hE) : i_idx);
endmodule
`default_nettype wire

// ==== rtl/event_flag_bit.v ====
`timescale 1ns/1ps
`default_nettype none
module event_flag_bit (
   input wire i_clk,
   input wire i_arst_n,
   input wire i_init,
   input wire i_set,
   input wire i_read,
   input wire i_write0,
   output reg o_flag
);
   reg armed;
   always @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_flag <= 1'b0;
         armed <= 1'b0;
      end else if (i_init) begin
         o_flag <= 1'b0;
         armed <= 1'b0;
      end else begin
         // Set wins over a clear in the same cycle
         if (i_set) begin
            o_flag <= 1'b1;
         end else if (i_write0 && armed) begin
            o_flag <= 1'b0;
         end
         if (i_set || (i_write0 && armed)) begin
            armed <= 1'b0;
         end else if (i_read && o_flag) begin
            armed <= 1'b1;
         end
      end
   end
endmodule
`default_nettype wire

// ==== rtl/timer_status_irq_consts.vh ====
`ifndef TIMER_STATUS_IRQ_CONSTS_VH
`define TIMER_STATUS_IRQ_CONSTS_VH
`define NUM_CH 5
`define REG_RESET 8'hF8
`define RSVD_MASK 8'hF8
`define BIT_WRAP 2
`define BIT_B 1
`define BIT_A 0
`define CH_PHASE 2
`define CH_CPWM_LO 3
`define CH_CPWM_HI 4
// Byte index of the first flag, first enable and last register inside the 8-bit window
`define IDX_FLAGS0 4'h0
`define IDX_EN0 4'h5
`define IDX_LAST 4'h9
`endif

// ==== rtl/timer_status_irq_regs.v ====
`timescale 1ns/1ps
`default_nettype none
`include "timer_status_irq_consts.vh"
// 8-bit register window: index 0..4 flag registers, 5..9 enable registers.
// Word accesses are run as two byte cycles; the CPU waits on o_wait.
module timer_status_irq_regs (
   input wire I_CLK,
   input wire I_ARST_N,
   input wire i_standby,
   input wire i_req,
   input wire i_wr,
   input wire i_word,
   input wire [3:0] i_idx,
   input wire [15:0] i_wdata,
   input wire [4:0] i_cnt_wrap_up,
   input wire [4:0] i_cnt_wrap_down,
   input wire i_phase_count_select,
   input wire i_complementary_pwm_select,
   input wire [4:0] i_match_a,
   input wire [4:0] i_match_b,
   input wire [4:0] i_capture_a,
   input wire [4:0] i_capture_b,
   input wire [4:0] i_a_is_capture,
   input wire [4:0] i_b_is_capture,
   output wire o_wait,
   output reg [15:0] o_rdata,
   output reg o_rvalid,
   output wire [4:0] o_wrap_irq,
   output wire [4:0] o_match_capture_irq_a,
   output wire [4:0] o_match_capture_irq_b
);
   wire busy;
   wire xfer;
   wire [3:0] bidx;
   wire second;
   reg wr_hold;
   reg [7:0] wdata_lo;
   wire acc_wr;
   wire [7:0] bdata;
   wire [7:0] rbyte;
   reg [7:0] rd_hi;
   wire [`NUM_CH*8-1:0] flags_rd;
   wire [`NUM_CH*8-1:0] en_rd;

   byte_sequencer u_seq (
      .i_clk(I_CLK),
      .i_arst_n(I_ARST_N),
      .i_req(i_req && !busy),
      .i_word(i_word),
      .i_idx(i_idx),
      .o_busy(busy),
      .o_xfer(xfer),
      .o_idx(bidx),
      .o_second(second)
   );

   // Word data is big-endian: high byte to the even register
   assign acc_wr = second ? wr_hold : i_wr;
   assign bdata = second ? wdata_lo : (i_word ? i_wdata[15:8] : i_wdata[7:0]);
   assign o_wait = busy;

   always @(posedge I_CLK or negedge I_ARST_N) begin
      if (!I_ARST_N) begin
         wr_hold <= 1'b0;
         wdata_lo <= 8'h00;
      end else if (i_req && !busy) begin
         wr_hold <= i_wr;
         wdata_lo <= i_wdata[7:0];
      end
   end

   genvar ch;
   generate
      for (ch = 0; ch < `NUM_CH; ch = ch + 1) begin : g_ch
         wire sel_f = xfer && (bidx == `IDX_FLAGS0 + ch);
         wire sel_e = xfer && (bidx == `IDX_EN0 + ch);
         wire rd_f = sel_f && !acc_wr;
         wire wr_f = sel_f && acc_wr;
         wire updown;
         wire wrap_ev;
         wire [2:0] flag;
         reg [2:0] en;
         if (ch == `CH_PHASE) begin : g_pc
            assign updown = i_phase_count_select;
         end else if (ch == `CH_CPWM_LO || ch == `CH_CPWM_HI) begin : g_cp
            assign updown = i_complementary_pwm_select;
         end else begin : g_up
            assign updown = 1'b0;
         end
         assign wrap_ev = i_cnt_wrap_up[ch] || (updown && i_cnt_wrap_down[ch]);
         event_flag_bit u_wrap (
            .i_clk(I_CLK),
            .i_arst_n(I_ARST_N),
            .i_init(i_standby),
            .i_set(wrap_ev),
            .i_read(rd_f),
            .i_write0(wr_f && !bdata[`BIT_WRAP]),
            .o_flag(flag[`BIT_WRAP])
         );
         event_flag_bit u_fb (
            .i_clk(I_CLK),
            .i_arst_n(I_ARST_N),
            .i_init(i_standby),
            .i_set(i_b_is_capture[ch] ? i_capture_b[ch] : i_match_b[ch]),
            .i_read(rd_f),
            .i_write0(wr_f && !bdata[`BIT_B]),
            .o_flag(flag[`BIT_B])
         );
         event_flag_bit u_fa (
            .i_clk(I_CLK),
            .i_arst_n(I_ARST_N),
            .i_init(i_standby),
            .i_set(i_a_is_capture[ch] ? i_capture_a[ch] : i_match_a[ch]),
            .i_read(rd_f),
            .i_write0(wr_f && !bdata[`BIT_A]),
            .o_flag(flag[`BIT_A])
         );
         always @(posedge I_CLK or negedge I_ARST_N) begin
            if (!I_ARST_N) begin
               en <= 3'h0;
            end else if (i_standby) begin
               en <= 3'h0;
            end else if (sel_e && acc_wr) begin
               en <= bdata[2:0];
            end
         end
         assign flags_rd[ch*8+7:ch*8] = `RSVD_MASK | {5'h00, flag};
         assign en_rd[ch*8+7:ch*8] = `RSVD_MASK | {5'h00, en};
         assign o_wrap_irq[ch] = flag[`BIT_WRAP] & en[`BIT_WRAP];
         assign o_match_capture_irq_b[ch] = flag[`BIT_B] & en[`BIT_B];
         assign o_match_capture_irq_a[ch] = flag[`BIT_A] & en[`BIT_A];
      end
   endgenerate

   // Unmapped indices read as all ones, like the reserved bits
   assign rbyte = (bidx < `IDX_EN0) ? flags_rd[bidx*8 +: 8] :
                  (bidx <= `IDX_LAST) ? en_rd[(bidx - `IDX_EN0)*8 +: 8] : 8'hFF;

   always @(posedge I_CLK or negedge I_ARST_N) begin
      if (!I_ARST_N) begin
         o_rdata <= 16'h0000;
         o_rvalid <= 1'b0;
         rd_hi <= 8'h00;
      end else begin
         o_rvalid <= 1'b0;
         if (xfer && !acc_wr) begin
            if (second) begin
               o_rdata <= {rd_hi, rbyte};
               o_rvalid <= 1'b1;
            end else if (i_word) begin
               rd_hi <= rbyte;
            end else begin
               o_rdata <= {8'h00, rbyte};
               o_rvalid <= 1'b1;
            end
         end
      end
   end
endmodule
`default_nettype wire

// ==== sim/event_source.sv ====
`timescale 1ns/1ps
`default_nettype none
module event_source (
   input wire i_clk,
   input wire i_fire,
   input wire [4:0] i_sel,
   output logic [29:0] o_stb
);
   // Strobes last one cycle, as the counters give them
   always @(posedge i_clk) begin
      o_stb <= i_fire ? 30'h1 << i_sel : 30'h0;
   end
endmodule
`default_nettype wire

// ==== sim/regs_chk.sv ====
`timescale 1ns/1ps
`default_nettype none
module regs_chk (
   input wire I_CLK,
   input wire I_ARST_N,
   input wire i_standby,
   input wire i_req,
   input wire i_wr,
   input wire i_word,
   input wire [4:0] i_cnt_wrap_up,
   input wire o_wait,
   input wire [15:0] o_rdata,
   input wire o_rvalid,
   input wire [4:0] o_wrap_irq,
   input wire [4:0] o_match_capture_irq_a
);
   default clocking dc @(posedge I_CLK); endclocking
   default disable iff (!I_ARST_N);
   wire tk = i_req && !o_wait;
   // Flag updates may land one or two edges after their cause
   wire bus = i_req || o_wait || i_standby;
   byte_read_a: assert property (tk && !i_wr && !i_word |=> o_rvalid && o_rdata[15:8] == 8'h00)
      else $error("byte read");
   word_wait_a: assert property (tk && i_word |=> o_wait ##1 !o_wait)
      else $error("word wait");
   word_read_a: assert property (tk && i_word && !i_wr |=> !o_rvalid ##1 o_rvalid)
      else $error("word read");
   rsvd_ones_a: assert property (o_rvalid |-> &o_rdata[7:3])
      else $error("reserved bits");
   standby_quiet_a: assert property (i_standby [*2] |-> (o_wrap_irq | o_match_capture_irq_a) == 5'h00)
      else $error("standby irq");
   wrap_cause_a: assert property ($rose(o_wrap_irq[0]) |-> $past(i_cnt_wrap_up[0] || bus) || $past(bus, 2))
      else $error("wrap irq cause");
   irq_hold_a: assert property (o_wrap_irq[0] && !i_req && !o_wait && !i_standby |=> o_wrap_irq[0])
      else $error("irq dropped");
   irq_fall_a: assert property ($fell(o_match_capture_irq_a[0]) |-> $past(bus) || $past(bus, 2))
      else $error("irq fall cause");
   cover property (tk && i_word && !i_wr);
   cover property ($fell(o_match_capture_irq_a[0]));
   cover property (i_standby [*2]);
endmodule
bind timer_status_irq_regs regs_chk regs_chk_inst (.I_CLK, .I_ARST_N, .i_standby, .i_req, .i_wr, .i_word,
   .i_cnt_wrap_up, .o_wait, .o_rdata, .o_rvalid, .o_wrap_irq, .o_match_capture_irq_a);
`default_nettype wire

// ==== sim/tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic I_CLK = 0, I_ARST_N = 0, i_standby = 0, i_req = 0, i_wr = 0, i_word = 0, fire = 0, ph = 0, cp = 0;
   logic [3:0] i_idx = 4'h0;
   logic [15:0] i_wdata = 16'h0000;
   logic [4:0] sel = 5'h00;
   logic [29:0] s;
   logic [15:0] o_rdata;
   logic o_wait, o_rvalid;
   logic [4:0] wi, ia, ib;
   int n_mismatch = 0, checks_done = 0, cyc = 0;
   initial forever #12.5 I_CLK = ~I_CLK;
   event_source event_source_inst (.i_clk(I_CLK), .i_fire(fire), .i_sel(sel), .o_stb(s));
   timer_status_irq_regs timer_status_irq_regs_inst (.I_CLK, .I_ARST_N, .i_standby, .i_req, .i_wr, .i_word, .i_idx,
      .i_wdata, .i_cnt_wrap_up(s[4:0]), .i_cnt_wrap_down(s[9:5]), .i_phase_count_select(ph),
      .i_complementary_pwm_select(cp), .i_match_a(s[14:10]), .i_match_b(s[19:15]), .i_capture_a(s[24:20]),
      .i_capture_b(s[29:25]), .i_a_is_capture(5'h10), .i_b_is_capture(5'h01), .o_wait, .o_rdata, .o_rvalid,
      .o_wrap_irq(wi), .o_match_capture_irq_a(ia), .o_match_capture_irq_b(ib));
   task report_and_stop();
      $display("checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task chk(input logic [15:0] got, input logic [15:0] exp);
      checks_done++;
      if (got !== exp) begin
         n_mismatch++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task acc(input logic w, input logic d, input logic [3:0] i, input logic [15:0] v);
      @(posedge I_CLK);
      i_req <= 1;
      i_wr <= w;
      i_word <= d;
      i_idx <= i;
      i_wdata <= v;
      @(posedge I_CLK);
      i_req <= 0;
      if (d) @(posedge I_CLK);
      #1;
      if (!w) chk(o_rvalid === 1'b1 ? o_rdata : ~v, v);
   endtask
   task ev(input logic [4:0] k);
      @(posedge I_CLK);
      fire <= 1;
      sel <= k;
      @(posedge I_CLK);
      fire <= 0;
      @(posedge I_CLK);
      #1;
   endtask
   always @(posedge I_CLK) begin
      cyc <= cyc + 1;
      if (cyc == 2000) begin
         n_mismatch++;
         report_and_stop();
      end
   end
   initial begin
      repeat (6) @(posedge I_CLK);
      I_ARST_N <= 1;
      for (int i = 0; i < 10; i++) acc(0, 0, i[3:0], 16'h00F8);
      acc(0, 0, 4'hA, 16'h00FF);
      acc(1, 0, 4'h5, 16'h00FF);
      acc(0, 0, 4'h5, 16'h00FF);
      acc(1, 0, 4'h5, 16'h0005);
      acc(0, 0, 4'h5, 16'h00FD);
      ev(5'd0);
      ev(5'd10);
      ev(5'd25);
      chk({1'b0, wi, ia, ib}, 16'h0420);
      // No read has armed the clear yet, so these zeros must not clear
      acc(1, 0, 4'h0, 16'h0000);
      acc(0, 0, 4'h0, 16'h00FF);
      acc(1, 0, 4'h0, 16'h00FE);
      acc(0, 0, 4'h0, 16'h00FE);
      chk({1'b0, wi, ia, ib}, 16'h0400);
      acc(1, 0, 4'h5, 16'h0000);
      chk({1'b0, wi, ia, ib}, 16'h0000);
      ev(5'd6);
      @(posedge I_CLK);
      ph <= 1;
      cp <= 1;
      ev(5'd7);
      ev(5'd8);
      ev(5'd19);
      ev(5'd24);
      acc(0, 0, 4'h1, 16'h00F8);
      acc(0, 1, 4'h2, 16'hFCFC);
      acc(0, 0, 4'h4, 16'h00FB);
      acc(1, 1, 4'h6, 16'h0007);
      acc(0, 1, 4'h6, 16'hF8FF);
      acc(1, 0, 4'h9, 16'h0007);
      chk({1'b0, wi, ia, ib}, 16'h1210);
      // Standby wipes the registers even without a reset
      @(posedge I_CLK);
      i_standby <= 1;
      repeat (2) @(posedge I_CLK);
      i_standby <= 0;
      acc(0, 0, 4'h4, 16'h00F8);
      acc(0, 1, 4'h6, 16'hF8F8);
      chk({1'b0, wi, ia, ib}, 16'h0000);
      report_and_stop();
   end
endmodule
`default_nettype wire
